// ---- design/lpm_ctrl.sv ----
// low-power mode controller: run, wait and stop sequencing, clock gating,
// stop recovery counter and an APB register slave.
// assumes clk is the reference clock; pins arrive asynchronously,
// CPU and peripheral strobes are on clk.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
`include "lpm_consts.svh"

module lpm_ctrl #(
  parameter int KEY_W = 4,
  parameter int REC_LONG = `LPM_REC_LONG
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic waitExec,
  input wire logic stopExec,
  output logic irqMaskFlag,
  output logic vectorLoad,
  output logic [15:0] vectorAddr,
  output logic deviceReset,
  // pins
  input wire logic extResetPin_b,
  input wire logic extPinIrq_b,
  input wire logic [KEY_W-1:0] keypadPins_b,
  input wire logic supplyLow,
  // peripheral requests on clk
  input wire logic converterIrq,
  input wire logic serialIrq,
  input wire logic syncPortIrq,
  input wire logic timerIrq,
  input wire logic timebaseRollover,
  input wire logic watchdogTimeout,
  // clock generator and peripheral controls
  output logic cpuClkEn,
  output logic busClkEn,
  output logic oscEnable,
  output logic pllEnable,
  output logic pllSelect,
  output logic genClocksEn,
  output logic watchdogClkEn,
  output logic sysCounterClear,
  output logic converterEnable,
  output logic converterAbort,
  output logic periphHalt,
  output logic syncPortReset,
  output logic timebaseEnable,
  output logic timebaseBlock
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SW = KEY_W + 3;
  localparam logic [`LPM_REC_W-1:0] REC_LONG_M1 = `LPM_REC_W'(REC_LONG - 1);
  localparam logic [`LPM_REC_W-1:0] REC_SHORT_M1 =
    `LPM_REC_W'(`LPM_REC_SHORT - 1);

  logic [SW-1:0] syncA_q, syncB_q, syncC_q, pinsRaw;

  assign pinsRaw = {supplyLow, extResetPin_b, extPinIrq_b, keypadPins_b};

  // idle levels: reset pin high, irq pins high, supply fine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncA_q <= {1'b0, {(SW-1){1'b1}}};
      syncB_q <= {1'b0, {(SW-1){1'b1}}};
      syncC_q <= {1'b0, {(SW-1){1'b1}}};
    end else if (ce) begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  logic supplyLowS, resetPinLow, pinFall, keyFall;

  assign supplyLowS = syncB_q[SW-1];
  assign resetPinLow = !syncB_q[SW-2];
  assign pinFall = syncC_q[SW-3] && !syncB_q[SW-3];
  assign keyFall = |(syncC_q[KEY_W-1:0] & ~syncB_q[KEY_W-1:0]);

  ////////////////////////////////////////////////////////////////////////
  // control register

  logic [`LPM_CTRL_W-1:0] ctrl_q;
  logic apbWr, addrOk;

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `LPM_OFS_CTRL) || (a == `LPM_OFS_STATUS);
  endfunction

  assign addrOk = isMapped(paddr);
  assign apbWr = psel && penable && pwrite && addrOk;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= `LPM_CTRL_RST;
    end else if (ce && apbWr && paddr == `LPM_OFS_CTRL) begin
      ctrl_q <= pwdata[`LPM_CTRL_W-1:0];
    end
  end

  logic oscRun, stopEn, shortRec, pinMask, keyMask;
  logic monEn, monRst, monStop, wdogEn;

  assign oscRun = ctrl_q[`LPM_CB_OSC_RUN];
  assign stopEn = ctrl_q[`LPM_CB_STOP_EN];
  assign shortRec = ctrl_q[`LPM_CB_SHORT_REC];
  assign pinMask = ctrl_q[`LPM_CB_PIN_MASK];
  assign keyMask = ctrl_q[`LPM_CB_KEY_MASK];
  assign monEn = ctrl_q[`LPM_CB_MON_EN];
  assign monRst = ctrl_q[`LPM_CB_MON_RST];
  assign monStop = ctrl_q[`LPM_CB_MON_STOP];
  assign wdogEn = ctrl_q[`LPM_CB_WDOG_EN];

  ////////////////////////////////////////////////////////////////////////
  // wake and reset sources

  lpm_pkg::lpm_mode_t mode_q;
  logic inStop, inWait, monAlive, resetReq;
  logic pinWake, keyWake, tbWake, periphWake, stopWake;

  assign inStop = (mode_q == lpm_pkg::MODE_STOP);
  assign inWait = (mode_q == lpm_pkg::MODE_WAIT);
  // monitor only sees stop when allowed to run there
  assign monAlive = monEn && (!inStop || monStop);
  assign resetReq = resetPinLow
    || (supplyLowS && monAlive && monRst)
    || (watchdogTimeout && wdogEn && !inStop);
  assign pinWake = pinFall && !pinMask;
  assign keyWake = keyFall && !keyMask;
  // timebase is dead in stop without the oscillator
  assign tbWake = timebaseRollover && (!inStop || oscRun);
  assign periphWake = converterIrq || serialIrq || syncPortIrq
    || timerIrq;
  assign stopWake = resetReq || pinWake || keyWake || tbWake;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing

  lpm_pkg::lpm_wake_t wake_q, wakeSrc;
  logic [`LPM_REC_W-1:0] recCnt_q;
  logic stopAccept, recDone, wakeNow;

  assign stopAccept = stopExec && stopEn;
  assign recDone = (mode_q == lpm_pkg::MODE_RECOVER) && recCnt_q == '0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= lpm_pkg::MODE_RUN;
    end else if (ce) begin
      unique case (mode_q)
        lpm_pkg::MODE_RUN: begin
          if (stopAccept) begin
            mode_q <= lpm_pkg::MODE_STOP;
          end else if (waitExec) begin
            mode_q <= lpm_pkg::MODE_WAIT;
          end
        end
        lpm_pkg::MODE_WAIT: begin
          if (resetReq || pinWake || keyWake || tbWake || periphWake) begin
            mode_q <= lpm_pkg::MODE_RUN;
          end
        end
        lpm_pkg::MODE_STOP: begin
          if (resetReq || pinWake || keyWake || tbWake) begin
            mode_q <= lpm_pkg::MODE_RECOVER;
          end
        end
        lpm_pkg::MODE_RECOVER: begin
          if (recDone) begin
            mode_q <= lpm_pkg::MODE_RUN;
          end
        end
      endcase
    end
  end

  // recovery length latched at stop exit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      recCnt_q <= '0;
    end else if (ce) begin
      if (inStop && (resetReq || pinWake || keyWake || tbWake)) begin
        recCnt_q <= shortRec ? REC_SHORT_M1 : REC_LONG_M1;
      end else if (mode_q == lpm_pkg::MODE_RECOVER && !recDone) begin
        recCnt_q <= recCnt_q - 1'b1;
      end
    end
  end

  // wake source, highest priority first
  assign wakeNow = (inStop && stopWake)
    || (inWait && (stopWake || periphWake));
  assign wakeSrc = resetReq ? lpm_pkg::WAKE_RESET
    : pinWake ? lpm_pkg::WAKE_PIN : keyWake ? lpm_pkg::WAKE_KEY
    : tbWake ? lpm_pkg::WAKE_TBASE : lpm_pkg::WAKE_PERIPH;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_q <= lpm_pkg::WAKE_NONE;
    end else if (ce && wakeNow) begin
      wake_q <= wakeSrc;
    end
  end

  function automatic logic [15:0] vecOf(input lpm_pkg::lpm_wake_t w);
    unique case (w)
      lpm_pkg::WAKE_RESET: vecOf = `LPM_VEC_RESET;
      lpm_pkg::WAKE_PIN: vecOf = `LPM_VEC_PIN;
      lpm_pkg::WAKE_KEY: vecOf = `LPM_VEC_KEY;
      lpm_pkg::WAKE_TBASE: vecOf = `LPM_VEC_TBASE;
      default: vecOf = `LPM_VEC_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // CPU handoff: vector, reset pulse, interrupt mask

  logic leaveWait, resetNow;

  // leaving wait is immediate; stop waits for the recovery count
  assign leaveWait = inWait && wakeNow;
  assign resetNow = (mode_q != lpm_pkg::MODE_RECOVER) && resetReq;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vectorLoad <= 1'b0;
      vectorAddr <= `LPM_VEC_RESET;
      deviceReset <= 1'b0;
      syncPortReset <= 1'b0;
    end else if (ce) begin
      vectorLoad <= leaveWait || recDone;
      if (leaveWait) begin
        vectorAddr <= vecOf(wakeSrc);
      end else if (recDone) begin
        vectorAddr <= vecOf(wake_q);
      end
      // reset out of run and wait at once, out of stop after recovery
      deviceReset <= (resetNow && !inStop)
        || (recDone && wake_q == lpm_pkg::WAKE_RESET);
      syncPortReset <= recDone && wake_q == lpm_pkg::WAKE_RESET;
    end
  end

  // mask set by any reset outside recovery, cleared by accepted wait or stop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqMaskFlag <= 1'b1;
    end else if (ce) begin
      if (resetNow) begin
        irqMaskFlag <= 1'b1;
      end else if (mode_q == lpm_pkg::MODE_RUN
        && (stopAccept || waitExec)) begin
        irqMaskFlag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock and peripheral gating

  logic asleep, entering;

  assign asleep = inStop || mode_q == lpm_pkg::MODE_RECOVER;
  assign entering = ce && mode_q == lpm_pkg::MODE_RUN && stopAccept;

  assign cpuClkEn = mode_q == lpm_pkg::MODE_RUN;
  assign busClkEn = !asleep || (inStop && oscRun);
  // oscillator runs through recovery so it can stabilise
  assign oscEnable = !inStop || oscRun;
  assign genClocksEn = oscEnable;
  assign pllEnable = ctrl_q[`LPM_CB_PLL_ON] && !asleep;
  assign pllSelect = ctrl_q[`LPM_CB_PLL_SEL] && !asleep;
  assign watchdogClkEn = !asleep;
  assign converterEnable = !asleep;
  assign periphHalt = asleep;
  assign timebaseEnable = !asleep || oscRun;
  assign timebaseBlock = inWait || asleep;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sysCounterClear <= 1'b0;
      converterAbort <= 1'b0;
    end else if (ce) begin
      sysCounterClear <= entering;
      converterAbort <= entering;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= '0;
      if (paddr == `LPM_OFS_CTRL) begin
        prdata[`LPM_CTRL_W-1:0] <= ctrl_q;
      end else if (paddr == `LPM_OFS_STATUS) begin
        prdata[`LPM_SB_MODE +: 2] <= mode_q;
        prdata[`LPM_SB_EXT_PIN_IRQ_MASK] <= irqMaskFlag;
        prdata[`LPM_SB_WAKE +: 3] <= wake_q;
        prdata[`LPM_SB_COUNT +: `LPM_REC_W] <= recCnt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_STOP_GATES: assert property (@(posedge clk) disable iff (!rst_b)
    inStop |-> !cpuClkEn && (busClkEn == oscRun))
    else $error("stop clock gating wrong");
  AST_WAIT_BUS: assert property (@(posedge clk) disable iff (!rst_b)
    inWait |-> !cpuClkEn && busClkEn)
    else $error("wait clock gating wrong");
  AST_WAIT_MASK: assert property (@(posedge clk) disable iff (!rst_b)
    ce && mode_q == lpm_pkg::MODE_RUN && waitExec && !stopAccept
    && !resetReq |=> !irqMaskFlag && inWait)
    else $error("wait entry left mask set");
  AST_STOP_MASK: assert property (@(posedge clk) disable iff (!rst_b)
    ce && mode_q == lpm_pkg::MODE_RUN && stopAccept && !resetReq
    |=> !irqMaskFlag && inStop)
    else $error("stop entry left mask set");
  AST_OSC_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    inStop && !oscRun |-> !oscEnable && !pllEnable && !genClocksEn)
    else $error("generator alive in stop");
  AST_OSC_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    inStop && oscRun |-> oscEnable && !pllEnable)
    else $error("osc option ignored in stop");
  AST_STOP_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    ce && mode_q == lpm_pkg::MODE_RUN && stopExec && !stopEn
    |=> mode_q != lpm_pkg::MODE_STOP)
    else $error("stop taken while disabled");
  AST_STOP_SIDE: assert property (@(posedge clk) disable iff (!rst_b)
    entering |=> sysCounterClear && converterAbort && !watchdogClkEn)
    else $error("stop entry side effects missing");
  AST_REC_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
    ce && inStop && shortRec && stopWake
    |=> recCnt_q == REC_SHORT_M1)
    else $error("short recovery not loaded");
  AST_REC_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == lpm_pkg::MODE_RECOVER |-> !cpuClkEn && !busClkEn)
    else $error("clocks released during recovery");
  AST_TB_BLOCK: assert property (@(posedge clk) disable iff (!rst_b)
    (inWait || inStop) |-> timebaseBlock)
    else $error("timebase reachable asleep");
  AST_KEY_MASKED: assert property (@(posedge clk) disable iff (!rst_b)
    ce && inStop && keyMask && !pinWake && !tbWake && !resetReq
    |=> inStop)
    else $error("masked keypad woke stop");

endmodule

// ---- design/lpm_consts.svh ----
// constants for the low-power mode controller: offsets, bits, counts
// assumes inclusion by bare name from the bench and the design file
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// register byte addresses
`define LPM_OFS_CTRL 12'h000
`define LPM_OFS_STATUS 12'h004

// control register bit positions
`define LPM_CB_OSC_RUN 0
`define LPM_CB_STOP_EN 1
`define LPM_CB_SHORT_REC 2
`define LPM_CB_PIN_MASK 3
`define LPM_CB_KEY_MASK 4
`define LPM_CB_MON_EN 5
`define LPM_CB_MON_RST 6
`define LPM_CB_MON_STOP 7
`define LPM_CB_WDOG_EN 8
`define LPM_CB_PLL_ON 9
`define LPM_CB_PLL_SEL 10
`define LPM_CTRL_W 11
`define LPM_CTRL_RST 11'h0_060

// status register fields
`define LPM_SB_MODE 0
`define LPM_SB_EXT_PIN_IRQ_MASK 2
`define LPM_SB_WAKE 3
`define LPM_SB_COUNT 8

// vectors
`define LPM_VEC_RESET 16'hFFFE
`define LPM_VEC_PIN 16'hFFFA
`define LPM_VEC_KEY 16'hFFE0
`define LPM_VEC_TBASE 16'hFFDC
`define LPM_VEC_NONE 16'h0000

// stop recovery in reference clock cycles
`define LPM_REC_LONG 4096
`define LPM_REC_SHORT 32
`define LPM_REC_W 12

`endif

// ---- design/lpm_pkg.sv ----
// types shared by the low-power mode controller
// assumes the constants header sits beside it
package lpm_pkg;
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP,
    MODE_RECOVER
  } lpm_mode_t;

  typedef enum logic [2:0] {
    WAKE_NONE,
    WAKE_RESET,
    WAKE_PIN,
    WAKE_KEY,
    WAKE_TBASE,
    WAKE_PERIPH
  } lpm_wake_t;
endpackage

// ---- tb/lpm_far_model.sv ----
// far-side model: cpu core that executes wait and stop instructions
// assumes the bench pulses goWait or goStop for one clk cycle
`timescale 1ns/1ns
module lpm_far_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic goWait,
  input wire logic goStop,
  input wire logic cpuClkEn,
  output logic waitExec,
  output logic stopExec
);
  //////////////////////////////////////////////////////////////////////////
  // a halted cpu fetches nothing, so it never issues a second request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      waitExec <= 1'b0;
    end else begin
      waitExec <= goWait && cpuClkEn;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stopExec <= 1'b0;
    end else begin
      stopExec <= goStop && cpuClkEn;
    end
  end
endmodule

// ---- tb/tb_low_power_mode_control.sv ----
// bench for the low-power mode controller: apb master, pins, cpu model
// assumes recovery parameter shortened to REC cycles
`timescale 1ns/1ns
`include "lpm_consts.svh"
module tb_low_power_mode_control;
  localparam int REC = 64;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic goWait, goStop, waitExec, stopExec, irqMaskFlag, vectorLoad;
  logic [15:0] vectorAddr;
  logic deviceReset, extResetPin_b, extPinIrq_b, supplyLow;
  logic [3:0] keypadPins_b, periphReq;
  logic timebaseRollover, watchdogTimeout, cpuClkEn, busClkEn, oscEnable;
  logic pllEnable, pllSelect, genClocksEn, watchdogClkEn, sysCounterClear;
  logic converterEnable, converterAbort, periphHalt, syncPortReset;
  logic timebaseEnable, timebaseBlock;
  int error_cnt, cmp_count, cycles, c;

  lpm_ctrl #(.KEY_W(4), .REC_LONG(REC)) dut_u (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .waitExec(waitExec),
    .stopExec(stopExec), .irqMaskFlag(irqMaskFlag),
    .vectorLoad(vectorLoad), .vectorAddr(vectorAddr),
    .deviceReset(deviceReset), .extResetPin_b(extResetPin_b),
    .extPinIrq_b(extPinIrq_b), .keypadPins_b(keypadPins_b),
    .supplyLow(supplyLow), .converterIrq(periphReq[0]),
    .serialIrq(periphReq[1]), .syncPortIrq(periphReq[2]),
    .timerIrq(periphReq[3]), .timebaseRollover(timebaseRollover),
    .watchdogTimeout(watchdogTimeout), .cpuClkEn(cpuClkEn),
    .busClkEn(busClkEn), .oscEnable(oscEnable), .pllEnable(pllEnable),
    .pllSelect(pllSelect), .genClocksEn(genClocksEn),
    .watchdogClkEn(watchdogClkEn), .sysCounterClear(sysCounterClear),
    .converterEnable(converterEnable), .converterAbort(converterAbort),
    .periphHalt(periphHalt), .syncPortReset(syncPortReset),
    .timebaseEnable(timebaseEnable), .timebaseBlock(timebaseBlock)
  );

  lpm_far_model model_u (
    .clk(clk), .rst_b(rst_b), .goWait(goWait), .goStop(goStop),
    .cpuClkEn(cpuClkEn), .waitExec(waitExec), .stopExec(stopExec)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // sampled 1 ns after the edge so registered outputs have landed
  task automatic enter(input logic stop, output logic pulse);
    int k;
    @(posedge clk);
    goWait <= !stop;
    goStop <= stop;
    @(posedge clk);
    goWait <= 1'b0;
    goStop <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (cpuClkEn !== 1'b0 && k < 8);
    pulse = sysCounterClear && converterAbort;
  endtask

  task automatic wake(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (vectorLoad !== 1'b1 && deviceReset !== 1'b1 && n < 300);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, `LPM_OFS_CTRL, 32'h0000_0000, rd, e);
    chk("ctrl reset", 32'h0000_0060, rd);
    apb(1'b0, `LPM_OFS_STATUS, 32'h0000_0000, rd, e);
    chk("status reset", 3'b100, rd[2:0]);
    chk("reset clocks", 3'b111, {cpuClkEn, busClkEn, irqMaskFlag});
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF, rd, e);
    chk("unmapped wr err", 1, e);
    apb(1'b0, 12'h0F0, 32'h0000_0000, rd, e);
    chk("unmapped rd", 32'h0000_0000, rd);
    chk("unmapped rd err", 1, e);
    apb(1'b1, `LPM_OFS_CTRL, 32'hFFFF_F800, rd, e);
    apb(1'b0, `LPM_OFS_CTRL, 32'h0000_0000, rd, e);
    chk("ctrl upper bits", 0, rd);
    apb(1'b1, `LPM_OFS_CTRL, 32'h0000_0060, rd, e);
  endtask

  task automatic t_stop_refused();
    enter(1'b1, p);
    chk("refused stop", 3'b110, {cpuClkEn, irqMaskFlag, p});
  endtask

  task automatic t_wait();
    for (int i = 0; i < 4; i++) begin
      // pll powered but deselected, keypad masked
      apb(1'b1, `LPM_OFS_CTRL, 32'h0000_0270, rd, e);
      enter(1'b0, p);
      chk("wait clocks", 2'b01, {cpuClkEn, busClkEn});
      chk("wait irqMaskFlag", 0, irqMaskFlag);
      chk("wait pll", 3'b110, {genClocksEn, pllEnable, pllSelect});
      chk("wait timebaseBlock", 1, timebaseBlock);
      apb(1'b0, `LPM_OFS_STATUS, 32'h0000_0000, rd, e);
      chk("wait mode", 1, rd[1:0]);
      @(posedge clk);
      keypadPins_b[i] <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk("masked keypad", 0, cpuClkEn);
      @(posedge clk);
      keypadPins_b[i] <= 1'b1;
      periphReq[i] <= 1'b1;
      wake(c);
      chk("wait wake cycles", 1, c);
      chk("wait vector", 16'h0000, vectorAddr);
      @(posedge clk);
      periphReq[i] <= 1'b0;
      #1;
      chk("run after wait", 2'b10, {cpuClkEn, irqMaskFlag});
      chk("run timebaseBlock", 0, timebaseBlock);
    end
  endtask

  task automatic t_wdog();
    apb(1'b1, `LPM_OFS_CTRL, 32'h0000_0160, rd, e);
    enter(1'b0, p);
    chk("wait watchdog clk", 1, watchdogClkEn);
    @(posedge clk);
    watchdogTimeout <= 1'b1;
    wake(c);
    chk("watchdog reset", 1, deviceReset);
    chk("watchdog wake cycles", 1, c);
    @(posedge clk);
    watchdogTimeout <= 1'b0;
    #1;
    chk("watchdog mask", 1, irqMaskFlag);
  endtask

  task automatic t_stop_exit();
    // short recovery only with the oscillator kept running
    logic [31:0] cfgs [3] = '{32'h0000_0072, 32'h0000_0067, 32'h0000_0063};
    logic [15:0] vecs [3] = '{16'hFFFA, 16'hFFE0, 16'hFFDC};
    int recs [3] = '{REC, `LPM_REC_SHORT, REC};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `LPM_OFS_CTRL, cfgs[i], rd, e);
      enter(1'b1, p);
      chk("stop pulses", 1, p);
      chk("stop cpu", 2'b00, {cpuClkEn, irqMaskFlag});
      chk("stop bus", cfgs[i][0], busClkEn);
      chk("stop osc pll", {cfgs[i][0], 1'b0}, {oscEnable, pllEnable});
      if (cfgs[i][0] == 1'b0) begin
        chk("stop gen clocks", 0, genClocksEn);
      end
      chk("stop watchdog clk", 0, watchdogClkEn);
      chk("stop halt", 3'b101,
          {periphHalt, converterEnable, timebaseBlock});
      chk("stop timebase", cfgs[i][0], timebaseEnable);
      @(posedge clk);
      extPinIrq_b <= (i != 0);
      keypadPins_b[1] <= (i != 1);
      timebaseRollover <= (i == 2);
      @(posedge clk);
      timebaseRollover <= 1'b0;
      wake(c);
      chk("stop exit vector", vecs[i], vectorAddr);
      chk("recovery window", 1, c >= recs[i] && c <= recs[i] + 6);
      @(posedge clk);
      extPinIrq_b <= 1'b1;
      keypadPins_b[1] <= 1'b1;
      #1;
      chk("resume", 4'b1010, {cpuClkEn, irqMaskFlag, converterEnable,
          periphHalt});
    end
  endtask

  task automatic t_stop_reset();
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `LPM_OFS_CTRL, 32'h0000_00E2, rd, e);
      enter(1'b1, p);
      @(posedge clk);
      extResetPin_b <= (j != 0);
      supplyLow <= (j == 1);
      repeat (3) @(posedge clk);
      extResetPin_b <= 1'b1;
      supplyLow <= 1'b0;
      wake(c);
      chk("reset exit vector", 16'hFFFE, vectorAddr);
      chk("reset exit pulses", 3'b111, {vectorLoad, deviceReset,
          syncPortReset});
      @(posedge clk);
      #1;
      chk("reset exit mask", 1, irqMaskFlag);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ceiling well above the roughly 470 cycles the sequence needs
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 5000) begin
        error_cnt++;
        $display("MISMATCH timeout exp 0 got 1");
        end_sim();
      end
    end
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    {psel, penable, pwrite, goWait, goStop} = 5'b0_0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {extResetPin_b, extPinIrq_b, supplyLow} = 3'b110;
    keypadPins_b = 4'hF;
    periphReq = 4'h0;
    timebaseRollover = 1'b0;
    watchdogTimeout = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_stop_refused();
    t_wait();
    t_wdog();
    t_stop_exit();
    t_stop_reset();
    end_sim();
  end
endmodule
